// ---- core/ep_reply_regs.vh ----
// Register map and constants for the endpoint reply control block
// Notes on behaviour
// - Auto NAK sets hold-off after clean transaction
// - Short enable sends partial FIFO as short
// - Short enable clears after short IN completes
// - Short enable with empty FIFO sends zero-length
// - Short OUT packet sets hold-off when active
// - Short OUT auto NAK on by default
// - Auto NAK on completion wins over disable
// - Data toggle shown as read-only status
// - Toggle set forces one, clear wins
// - Hold-off forces NAK on every transaction unless halt forces STALL
// - Hold-off set deferred until clean transaction end, dropped if it ends in error
// - Halt forces STALL, above NAK
// - Halt set mid-transaction applies from next
// - Eleven-bit packet size limit decides short packets
// - Direction bit: one is IN, zero OUT
`ifndef EP_REPLY_REGS_VH
`define EP_REPLY_REGS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_CONTROL     12'h11C
`define ADDR_CONFIG      12'h11A
`define ADDR_SIZE_HI     12'h118
`define ADDR_SIZE_LO     12'h119

// ****************************************
// Control register fields
// ****************************************
`define CTL_AUTO_NAK     7
`define CTL_SHORT_EN     6
`define CTL_SOUT_DIS     5
`define CTL_TOGGLE       4
`define CTL_TOG_SET      3
`define CTL_TOG_CLR      2
`define CTL_HOLD         1
`define CTL_HALT         0

// ****************************************
// Config register fields
// ****************************************
`define CFG_DIR          7
`define CFG_INT_MODE     6
`define CFG_ISO          5
`define CFG_ID_HI        3
`define CFG_ID_LO        0

`define RESET_BYTE       8'h00

// ****************************************
// Reply codes
// ****************************************
`define REPLY_DATA       2'h0
`define REPLY_NAK        2'h1
`define REPLY_STALL      2'h2

`endif

// ---- core/ep_reply_ctrl.v ----
// Endpoint reply control with classic Wishbone register slave
`timescale 1ns/1ps
`include "ep_reply_regs.vh"

module ep_reply_ctrl #(
    parameter SIZE_W = 11
) (
    input  wire              clk_i,
    input  wire              rst_i,
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [11:0]       wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output reg  [31:0]       wb_dat_o,
    output wire              wb_ack_o,
    input  wire              token_valid_i,
    input  wire [3:0]        token_ep_i,
    input  wire              token_in_i,
    input  wire [SIZE_W-1:0] fifo_count_i,
    input  wire              trans_done_i,
    input  wire              trans_error_i,
    input  wire [SIZE_W-1:0] trans_bytes_i,
    input  wire              data_toggled_i,
    output wire              token_match_o,
    output reg  [1:0]        reply_code_o,
    output reg  [SIZE_W-1:0] send_bytes_o,
    output reg               reply_valid_o,
    output wire              busy_o,
    output wire              data_toggle_o,
    output wire              iso_mode_o,
    output wire              int_mode_o
);

// ****************************************
// Register state
// ****************************************
reg              auto_nak_on_done_reg;
reg              short_packet_enable_reg;
reg              short_out_autonak_disable_reg;
reg              data_toggle_state_reg;
reg              hold_off_reply_reg;
reg              halt_reply_reg;
reg              hold_pending_reg;
reg              halt_active_reg;
reg              direction_select_reg;
reg              int_mode_reg;
reg              iso_reg;
reg  [3:0]       endpoint_identifier_reg;
reg  [SIZE_W-1:0] packet_size_limit_reg;
reg              busy_reg;
reg              ack_reg;
reg              short_sent_reg;

// ****************************************
// Wishbone decode
// ****************************************
wire        req      = wb_cyc_i & wb_stb_i & ~ack_reg;
// Write lands on the edge where the master sees ack high
wire        wr       = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
wire [11:0] word_adr = {wb_adr_i[11:2], 2'b00};
wire [1:0]  lane     = wb_adr_i[1:0];
wire [7:0]  wbyte    = wb_dat_i[8*lane +: 8];
wire        lane_sel = wb_sel_i[lane];
wire        wr_ctl   = wr & lane_sel & (word_adr == `ADDR_CONTROL);
wire        wr_cfg   = wr & lane_sel & (wb_adr_i == `ADDR_CONFIG);
wire        wr_shi   = wr & lane_sel & (wb_adr_i == `ADDR_SIZE_HI);
wire        wr_slo   = wr & lane_sel & (wb_adr_i == `ADDR_SIZE_LO);

assign wb_ack_o = ack_reg;

// ****************************************
// Transaction tracking
// ****************************************
assign token_match_o = token_valid_i & (token_ep_i == endpoint_identifier_reg)
                     & (token_in_i == direction_select_reg);
wire   done_ok  = trans_done_i & ~trans_error_i & busy_reg;
wire   is_short = (trans_bytes_i < packet_size_limit_reg);
assign busy_o        = busy_reg;
assign data_toggle_o = data_toggle_state_reg;
assign iso_mode_o    = iso_reg;
assign int_mode_o    = int_mode_reg;

// Hold-off next value: deferred software set, automatic sets
reg hold_next;
always @* begin
    hold_next = hold_off_reply_reg;
    if (wr_ctl) begin
        if (!wbyte[`CTL_HOLD]) begin
            hold_next = 1'b0;
        end else if (!busy_reg) begin
            hold_next = 1'b1;
        end
    end
    if (done_ok) begin
        if (hold_pending_reg) begin
            hold_next = 1'b1;
        end
        if (auto_nak_on_done_reg) begin
            hold_next = 1'b1;
        end else if (!short_out_autonak_disable_reg && !direction_select_reg && is_short) begin
            hold_next = 1'b1;
        end
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        auto_nak_on_done_reg          <= 1'b0;
        short_packet_enable_reg       <= 1'b0;
        short_out_autonak_disable_reg <= 1'b0;
        data_toggle_state_reg         <= 1'b0;
        hold_off_reply_reg            <= 1'b0;
        halt_reply_reg                <= 1'b0;
        hold_pending_reg              <= 1'b0;
        halt_active_reg               <= 1'b0;
        direction_select_reg          <= 1'b0;
        int_mode_reg                  <= 1'b0;
        iso_reg                       <= 1'b0;
        endpoint_identifier_reg       <= 4'h0;
        packet_size_limit_reg         <= {SIZE_W{1'b0}};
        busy_reg                      <= 1'b0;
        ack_reg                       <= 1'b0;
        short_sent_reg                <= 1'b0;
        reply_code_o                  <= `REPLY_DATA;
        send_bytes_o                  <= {SIZE_W{1'b0}};
        reply_valid_o                 <= 1'b0;
        wb_dat_o                      <= 32'h0000_0000;
    end else begin
        ack_reg       <= req;
        reply_valid_o <= 1'b0;
        hold_off_reply_reg <= hold_next;
        // Pending software set survives until the transaction ends
        if (wr_ctl && busy_reg) begin
            hold_pending_reg <= wbyte[`CTL_HOLD];
        end else if (done_ok || trans_done_i || !busy_reg) begin
            hold_pending_reg <= 1'b0;
        end
        if (wr_ctl) begin
            auto_nak_on_done_reg          <= wbyte[`CTL_AUTO_NAK];
            short_out_autonak_disable_reg <= wbyte[`CTL_SOUT_DIS];
            halt_reply_reg                <= wbyte[`CTL_HALT];
        end
        // Halt latched into the reply path only between transactions
        if (!busy_reg) begin
            halt_active_reg <= wr_ctl ? wbyte[`CTL_HALT] : halt_reply_reg;
        end
        // Short enable: software set wins over completion clear
        if (wr_ctl && wbyte[`CTL_SHORT_EN]) begin
            short_packet_enable_reg <= 1'b1;
        end else if (wr_ctl) begin
            short_packet_enable_reg <= 1'b0;
        end else if (done_ok && direction_select_reg && short_sent_reg) begin
            short_packet_enable_reg <= 1'b0;
        end
        // Toggle strobes: clear over set, then hardware toggles
        if (wr_ctl && wbyte[`CTL_TOG_CLR]) begin
            data_toggle_state_reg <= 1'b0;
        end else if (wr_ctl && wbyte[`CTL_TOG_SET]) begin
            data_toggle_state_reg <= 1'b1;
        end else if (data_toggled_i) begin
            data_toggle_state_reg <= ~data_toggle_state_reg;
        end
        if (wr_cfg) begin
            direction_select_reg    <= wbyte[`CFG_DIR];
            int_mode_reg            <= wbyte[`CFG_INT_MODE];
            iso_reg                 <= wbyte[`CFG_ISO];
            endpoint_identifier_reg <= wbyte[`CFG_ID_HI:`CFG_ID_LO];
        end
        if (wr_shi) begin
            packet_size_limit_reg[SIZE_W-1:8] <= wbyte[SIZE_W-9:0];
        end
        if (wr_slo) begin
            packet_size_limit_reg[7:0] <= wbyte;
        end
        // Reply decision on a matching token
        if (token_match_o && !busy_reg) begin
            busy_reg      <= 1'b1;
            reply_valid_o <= 1'b1;
            short_sent_reg <= 1'b0;
            send_bytes_o  <= {SIZE_W{1'b0}};
            if (halt_active_reg) begin
                reply_code_o <= `REPLY_STALL;
            end else if (hold_off_reply_reg) begin
                reply_code_o <= `REPLY_NAK;
            end else if (!direction_select_reg) begin
                reply_code_o <= `REPLY_DATA;
            end else if (fifo_count_i >= packet_size_limit_reg) begin
                reply_code_o <= `REPLY_DATA;
                send_bytes_o <= packet_size_limit_reg;
            end else if (short_packet_enable_reg) begin
                reply_code_o   <= `REPLY_DATA;
                send_bytes_o   <= fifo_count_i;
                short_sent_reg <= 1'b1;
            end else begin
                reply_code_o <= `REPLY_NAK;
            end
        end else if (trans_done_i) begin
            busy_reg <= 1'b0;
        end
        // Register read data
        wb_dat_o <= 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `ADDR_CONTROL: begin
                    wb_dat_o[7:0] <= {auto_nak_on_done_reg, short_packet_enable_reg,
                                      short_out_autonak_disable_reg,
                                      data_toggle_state_reg, 2'b00,
                                      hold_off_reply_reg, halt_reply_reg};
                end
                `ADDR_CONFIG: begin
                    wb_dat_o[23:16] <= {direction_select_reg, int_mode_reg, iso_reg,
                                        1'b0, endpoint_identifier_reg};
                end
                `ADDR_SIZE_HI: begin
                    wb_dat_o[7:0] <= {{(16-SIZE_W){1'b0}}, packet_size_limit_reg[SIZE_W-1:8]};
                end
                `ADDR_SIZE_LO: begin
                    wb_dat_o[15:8] <= packet_size_limit_reg[7:0];
                end
                default: begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end
end

endmodule

// ---- test/ep_reply_ctrl_monitor.sv ----
// Assertion checker for the endpoint reply control block
`timescale 1ns/1ps
`include "ep_reply_regs.vh"
module ep_reply_ctrl_monitor #(parameter SIZE_W = 11) (
    input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, token_valid_i,
    input wire logic token_in_i, trans_done_i, data_toggled_i, token_match_o,
    input wire logic reply_valid_o, busy_o, data_toggle_o,
    input wire logic [1:0] reply_code_o,
    input wire logic [SIZE_W-1:0] fifo_count_i, send_bytes_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    match_cause_a: assert property (token_match_o |-> token_valid_i)
        else $error("match without token");
    token_reply_a: assert property (token_match_o && !busy_o |=> reply_valid_o && busy_o)
        else $error("token not answered");
    busy_refuse_a: assert property (busy_o |=> !reply_valid_o)
        else $error("reply while busy");
    busy_end_a: assert property (busy_o && trans_done_i |=> !busy_o)
        else $error("busy after end");
    data_bytes_a: assert property (reply_valid_o && $past(token_in_i) &&
        reply_code_o == `REPLY_DATA |-> send_bytes_o <= $past(fifo_count_i))
        else $error("bytes above fifo level");
    toggle_cause_a: assert property ($changed(data_toggle_o) |->
        $past(wb_ack_o) || $past(data_toggled_i) || $past(rst_i)) else $error("toggle moved alone");
endmodule
bind ep_reply_ctrl ep_reply_ctrl_monitor #(.SIZE_W(SIZE_W)) mon (.*);

// ---- test/usb_host_model.sv ----
// Host model issuing tokens and ending transactions
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic   clk_i,
    output logic        token_valid_o = 1'b0, token_in_o = 1'b0,
    output logic        done_o = 1'b0, error_o = 1'b0,
    output logic [3:0]  token_ep_o = 4'h0,
    output logic [10:0] bytes_o = 11'h000
);
    task automatic tok(input logic [3:0] ep, input logic dir);
        @(posedge clk_i);
        token_valid_o <= 1'b1;
        token_ep_o <= ep;
        token_in_o <= dir;
        @(posedge clk_i);
        token_valid_o <= 1'b0;
        token_ep_o <= ~ep;
        token_in_o <= ~dir;
    endtask
    task automatic fin(input logic err, input logic [10:0] n);
        @(posedge clk_i);
        done_o <= 1'b1;
        error_o <= err;
        bytes_o <= n;
        @(posedge clk_i);
        done_o <= 1'b0;
        error_o <= ~err;
        bytes_o <= ~n;
    endtask
endmodule

// ---- test/ep_reply_ctrl_tb.sv ----
// Self-checking bench for the endpoint reply control block
`timescale 1ns/1ps
`include "ep_reply_regs.vh"
module ep_reply_ctrl_tb;
    localparam logic [11:0] ctl = `ADDR_CONTROL;
    localparam logic [10:0] full = 11'h040;
    localparam logic [1:0] dat = `REPLY_DATA, nak = `REPLY_NAK, stl = `REPLY_STALL;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0, token_ep_i;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
    logic [10:0] fifo_count_i = 11'h000, trans_bytes_i, send_bytes_o;
    logic [1:0] reply_code_o;
    logic wb_ack_o, token_valid_i, token_in_i, trans_done_i, trans_error_i, token_match_o;
    logic reply_valid_o, busy_o, data_toggle_o, iso_mode_o, int_mode_o, data_toggled_i = 1'b0;
    logic [7:0] mode [3] = '{8'h00, 8'h20, 8'hA0};
    int fails = 0, comparisons = 0;
    always #2.5 clk_i = ~clk_i;
    ep_reply_ctrl DUT (.*);
    usb_host_model host (.clk_i(clk_i), .token_valid_o(token_valid_i), .token_ep_o(token_ep_i),
        .token_in_o(token_in_i), .done_o(trans_done_i), .error_o(trans_error_i),
        .bytes_o(trans_bytes_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Bounded wait for ack (s = 0) or reply (s = 1)
    task automatic await(input bit s);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((s ? reply_valid_o : wb_ack_o) !== 1'b1 && n < 20);
        if ((s ? reply_valid_o : wb_ack_o) !== 1'b1) begin
            chk(0, 1);
            test_done;
        end
    endtask
    task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d, e);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1 << a[1:0];
        wb_dat_i <= {24'h000000, d} << (8 * a[1:0]);
        await(0);
        if (!we) chk(wb_dat_o >> (8 * a[1:0]), {24'h000000, e});
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic tok(input logic dir, input logic [10:0] f, b, input logic [1:0] c);
        fifo_count_i <= f; // Level moves only between transactions
        host.tok(4'h3, dir);
        await(1);
        chk(reply_code_o, c);
        if (c == dat) chk(send_bytes_o, b);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, ctl, 0, `RESET_BYTE);
        wb(0, 12'h100, 0, 0);
        wb(1, `ADDR_CONFIG, 8'h83, 0);
        wb(1, `ADDR_SIZE_LO, 8'h40, 0);
        wb(0, `ADDR_CONFIG, 0, 8'h83);
        wb(1, `ADDR_SIZE_HI, 8'h07, 0);
        wb(0, `ADDR_SIZE_HI, 0, 8'h07);
        wb(1, `ADDR_SIZE_HI, 8'h00, 0);
        wb(0, `ADDR_SIZE_LO, 0, 8'h40);
        for (int i = 0; i < 2; i++) begin
            host.tok(4'(4 - i), 1'(1 - i));
            @(posedge clk_i);
            chk(reply_valid_o, 0);
        end
        tok(1, 11'h00A, 0, nak);
        host.fin(0, 0);
        wb(1, ctl, 8'h40, 0);
        tok(1, 11'h00A, 11'h00A, dat);
        host.fin(0, 11'h00A);
        wb(0, ctl, 0, 8'h00);
        wb(1, ctl, 8'h40, 0);
        tok(1, full, full, dat);
        host.fin(0, full);
        wb(0, ctl, 0, 8'h40);
        tok(1, 0, 0, dat);
        host.fin(0, 0);
        wb(1, ctl, 8'h08, 0);
        wb(0, ctl, 0, 8'h10);
        wb(1, ctl, 8'h0C, 0);
        chk(data_toggle_o, 0);
        data_toggled_i <= 1'b1;
        @(posedge clk_i);
        data_toggled_i <= 1'b0;
        @(posedge clk_i);
        chk(data_toggle_o, 1);
        wb(1, ctl, 8'h04, 0);
        wb(1, ctl, 8'h02, 0);
        tok(1, full, 0, nak);
        host.fin(0, 0);
        wb(1, ctl, 8'h03, 0);
        tok(1, full, 0, stl);
        host.fin(0, 0);
        wb(1, ctl, 8'h00, 0);
        tok(1, full, full, dat);
        wb(1, ctl, 8'h03, 0);
        wb(0, ctl, 0, 8'h01);
        host.fin(0, full);
        wb(0, ctl, 0, 8'h03);
        wb(1, ctl, 8'h01, 0);
        tok(1, full, 0, stl);
        host.fin(0, 0);
        wb(1, ctl, 8'h80, 0);
        tok(1, full, full, dat);
        host.fin(1, full);
        wb(0, ctl, 0, 8'h80);
        tok(1, full, full, dat);
        host.fin(0, full);
        wb(0, ctl, 0, 8'h82);
        wb(1, `ADDR_CONFIG, 8'h03, 0);
        for (int i = 0; i < 3; i++) begin
            wb(1, ctl, mode[i], 0);
            tok(0, 0, 0, dat);
            host.fin(0, 11'h005);
            wb(0, ctl, 0, mode[i] | {6'h00, i != 1, 1'b0});
        end
        wb(1, `ADDR_CONFIG, 8'h63, 0);
        chk({iso_mode_o, int_mode_o}, 2'b11);
        wb(0, `ADDR_CONFIG, 0, 8'h63);
        test_done;
    end
endmodule
